// ### rtl/fsr_defs.vh
// Constants for the flash status, soft reset and parameter byte block
// How it works
// - Power-up loads status 1 from stored copy
// - 06h arms stored write, 50h volatile override
// - Reset only when 99h directly follows 66h
// - Reset pair accepted at current wire width
// - Parameter byte 6Dh reads constant 10h
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH
// ****************************************
// Instruction codes
// ****************************************
`define FSR_OP_WREN      8'h06
`define FSR_OP_VWREN     8'h50
`define FSR_OP_WRSR      8'h01
`define FSR_OP_RDSR      8'h05
`define FSR_OP_RSTEN     8'h66
`define FSR_OP_RST       8'h99
`define FSR_OP_RDPAR     8'h5A
// ****************************************
// Parameter table bytes
// ****************************************
`define FSR_PA_6C        8'h6C
`define FSR_PA_6D        8'h6D
`define FSR_PA_6E        8'h6E
`define FSR_PA_6F        8'h6F
`define FSR_PD_6C        8'hE8
`define FSR_PD_6D        8'h10
`define FSR_PD_6E        8'hC0
`define FSR_PD_6F        8'h80
`define FSR_PD_RSVD      8'hFF
// ****************************************
// Wire width modes and stored status reset value
// ****************************************
`define FSR_W1           2'h0
`define FSR_W2           2'h1
`define FSR_W4           2'h2
`define FSR_NV_RESET     8'h00
`endif

// ### rtl/fsr_param_rom.v
// Read-only parameter byte table with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.vh"
module fsr_param_rom (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire [7:0] i_addr,
   output reg  [7:0] o_data
);
   // ****************************************
   // Constant lookup, no write path exists
   // ****************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_data <= 8'h00;
      end else begin
         case (i_addr)
            `FSR_PA_6C: o_data <= `FSR_PD_6C;
            `FSR_PA_6D: o_data <= `FSR_PD_6D;
            `FSR_PA_6E: o_data <= `FSR_PD_6E;
            `FSR_PA_6F: o_data <= `FSR_PD_6F;
            default:    o_data <= `FSR_PD_RSVD;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### rtl/fsr_core.v
// Command interpreter for status 1 writes, soft reset and parameter reads
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.vh"
module fsr_core (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_cs_n,
   input  wire       i_sclk,
   input  wire [3:0] i_dq,
   input  wire [1:0] i_width,
   input  wire [7:0] i_nv_status,
   output reg  [3:0] o_dq,
   output reg  [3:0] o_dq_oe,
   output reg  [7:0] o_status,
   output reg  [7:0] o_nv_wdata,
   output reg        o_nv_we,
   output reg        o_soft_rst
);
   // ****************************************
   // States
   // ****************************************
   localparam ST_OP   = 3'h0;
   localparam ST_WSR  = 3'h1;
   localparam ST_ADR  = 3'h2;
   localparam ST_DMY  = 3'h3;
   localparam ST_OUT  = 3'h4;
   localparam ST_IGN  = 3'h5;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Two-flop synchronisers; only the second stage is used
   reg [3:0] dq_m_q, dq_s_q;
   reg       cs_m_q, cs_s_q, clk_m_q, clk_s_q, clk_p_q;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dq_m_q  <= 4'h0;
         dq_s_q  <= 4'h0;
         cs_m_q  <= 1'b1;
         cs_s_q  <= 1'b1;
         clk_m_q <= 1'b0;
         clk_s_q <= 1'b0;
         clk_p_q <= 1'b0;
      end else begin
         dq_m_q  <= i_dq;
         dq_s_q  <= dq_m_q;
         cs_m_q  <= i_cs_n;
         cs_s_q  <= cs_m_q;
         clk_m_q <= i_sclk;
         clk_s_q <= clk_m_q;
         clk_p_q <= clk_s_q;
      end
   end

   // SCLK edges seen in i_clk time; SCLK must stay well below i_clk/6
   wire rise = clk_s_q & ~clk_p_q;
   wire fall = ~clk_s_q & clk_p_q;
   wire sel  = ~cs_s_q;

   // Width is latched per frame; mid-frame changes would garble shifts
   reg  [1:0] wid_q;
   reg  [2:0] st_q;
   reg  [7:0] sh_q, op_q, adr_q;
   reg  [3:0] cnt_q;
   reg        cs_p_q;
   reg        wren_q, vwren_q, rsten_q, init_q;
   reg  [7:0] tx_q;
   reg  [1:0] ab_q;   // Address byte index in a table read
   wire [7:0] rom_data;

   // ****************************************
   // Shift datapath
   // ****************************************
   // Bits per edge follow the current interface mode
   wire [3:0] step = (wid_q == `FSR_W4) ? 4'h4 :
                     (wid_q == `FSR_W2) ? 4'h2 : 4'h1;
   // Next shift value for the latched width
   reg  [7:0] sh_n;
   always @* begin
      case (wid_q)
         `FSR_W4: sh_n = {sh_q[3:0], dq_s_q};
         `FSR_W2: sh_n = {sh_q[5:0], dq_s_q[1:0]};
         default: sh_n = {sh_q[6:0], dq_s_q[0]};
      endcase
   end
   // Byte boundary at eight bits, whatever the width
   wire [3:0] cnt_n  = cnt_q + step;
   wire       byte_ok = rise && (cnt_n == 4'h8);

   // ****************************************
   // Parameter table
   // ****************************************
   // Address settles long before the dummy byte ends
   fsr_param_rom u_rom (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_addr (adr_q),
      .o_data (rom_data)
   );

   // ****************************************
   // Frame decode
   // ****************************************
   // Enables and soft reset commit on CS rising; a status write lands
   // on its data byte, as soon as that byte is complete
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q       <= ST_OP;
         sh_q       <= 8'h00;
         op_q       <= 8'h00;
         adr_q      <= 8'h00;
         cnt_q      <= 4'h0;
         ab_q       <= 2'h0;
         cs_p_q     <= 1'b1;
         wid_q      <= `FSR_W1;
         wren_q     <= 1'b0;
         vwren_q    <= 1'b0;
         rsten_q    <= 1'b0;
         init_q     <= 1'b0;
         tx_q       <= 8'h00;
         o_status   <= 8'h00;
         o_nv_wdata <= 8'h00;
         o_nv_we    <= 1'b0;
         o_soft_rst <= 1'b0;
         o_dq       <= 4'h0;
         o_dq_oe    <= 4'h0;
      end else begin
         cs_p_q     <= cs_s_q;
         o_nv_we    <= 1'b0;
         o_soft_rst <= 1'b0;
         // Power-up copy of the stored value, taken after release
         if (!init_q) begin
            init_q   <= 1'b1;
            o_status <= i_nv_status;
         end
         // CS rising closes the frame and frees the shared wire
         if (cs_s_q && !cs_p_q) begin
            o_dq_oe <= 4'h0;
            if (st_q == ST_OP && cnt_q == 4'h0) begin
               // Pending reset-enable survives only one next command
               if (op_q == `FSR_OP_RST && rsten_q) begin
                  o_soft_rst <= 1'b1;
                  o_status   <= i_nv_status;
                  wren_q     <= 1'b0;
                  vwren_q    <= 1'b0;
               end
               rsten_q <= (op_q == `FSR_OP_RSTEN);
               if (op_q == `FSR_OP_WREN) wren_q <= 1'b1;
               if (op_q == `FSR_OP_VWREN) vwren_q <= 1'b1;
            end else begin
               rsten_q <= 1'b0;
            end
            op_q <= 8'h00;
         end else if (!sel) begin
            st_q  <= ST_OP;
            cnt_q <= 4'h0;
            ab_q  <= 2'h0;
            wid_q <= i_width;
         end else if (rise && st_q != ST_OUT && st_q != ST_IGN) begin
            sh_q  <= sh_n;
            cnt_q <= byte_ok ? 4'h0 : cnt_n;
            if (byte_ok) begin
               case (st_q)
                  ST_OP: begin
                     // One-byte opcodes wait in ST_OP for frame-end decode
                     op_q <= sh_n;
                     case (sh_n)
                        `FSR_OP_WRSR:  st_q <= ST_WSR;
                        `FSR_OP_RDPAR: st_q <= ST_ADR;
                        `FSR_OP_RDSR: begin
                           tx_q <= o_status;
                           st_q <= ST_OUT;
                        end
                        default:       st_q <= ST_OP;
                     endcase
                  end
                  ST_WSR: begin
                     // Volatile write wins over stored, until a soft reset or i_rst reloads status
                     if (vwren_q) begin
                        o_status <= sh_n;
                        vwren_q  <= 1'b0;
                     end else if (wren_q) begin
                        o_status   <= sh_n;
                        o_nv_wdata <= sh_n;
                        o_nv_we    <= 1'b1;
                        wren_q     <= 1'b0;
                     end
                     st_q <= ST_IGN;
                  end
                  ST_ADR: begin
                     // Three address bytes; the last one picks the entry
                     adr_q <= sh_n;
                     ab_q  <= ab_q + 2'h1;
                     if (ab_q == 2'h2) st_q <= ST_DMY;
                  end
                  ST_DMY: begin
                     // Step ahead so the next byte is ready at reload
                     tx_q  <= rom_data;
                     adr_q <= adr_q + 8'h01;
                     st_q  <= ST_OUT;
                  end
                  default: st_q <= ST_IGN;
               endcase
            end
         end else if (fall && st_q == ST_OUT) begin
            // Serial output on one wire, MSB first
            o_dq_oe <= 4'h2;
            o_dq    <= {2'b00, tx_q[7], 1'b0};
            tx_q    <= {tx_q[6:0], 1'b0};
            cnt_q   <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
               // Long parameter reads walk on through the table; status reads repeat o_status
               cnt_q <= 4'h0;
               tx_q  <= (op_q == `FSR_OP_RDPAR) ? rom_data : o_status;
               if (op_q == `FSR_OP_RDPAR) adr_q <= adr_q + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/fsr_properties.sv
// Checks on the status, soft reset and enable ports of the core
`timescale 1ns/1ps
`default_nettype none
module fsr_properties (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_cs_n,
   input wire logic [7:0] i_nv_status,
   input wire logic [3:0] o_dq_oe,
   input wire logic [7:0] o_status,
   input wire logic       o_nv_we,
   input wire logic       o_soft_rst
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Deselected long enough for any reply and pulse to end
   sequence s_idle; i_cs_n [*8]; endsequence
   // Frame closed for two samples
   sequence s_closed; i_cs_n ##1 i_cs_n; endsequence
   property p_pwr; $fell(i_rst) |=> o_status == $past(i_nv_status);
   endproperty
   property p_rld; o_soft_rst |-> ##[0:2] o_status == i_nv_status;
   endproperty
   property p_rpls; o_soft_rst |=> !o_soft_rst; endproperty
   property p_rcls; s_closed ##0 o_soft_rst |-> !$past(i_cs_n, 8);
   endproperty
   property p_wpls; o_nv_we |=> !o_nv_we; endproperty
   property p_quiet; s_idle |-> o_dq_oe == 4'h0; endproperty
   // Status only moves through instructions or reset
   property p_hold; s_idle ##0 !$past(i_rst) |=> $stable(o_status);
   endproperty
   a_pwr: assert property (p_pwr) else $error("bad load");
   a_rld: assert property (p_rld) else $error("no reload");
   a_rpls: assert property (p_rpls) else $error("long rst");
   a_rcls: assert property (p_rcls) else $error("no frame");
   a_wpls: assert property (p_wpls) else $error("long we");
   a_quiet: assert property (p_quiet) else $error("drives");
   a_hold: assert property (p_hold) else $error("moved");
endmodule
`default_nettype wire

// ### bench/fsr_host_model.sv
// Host side model: sends instruction frames, reads reply bits
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_width,
   input  wire logic [3:0] i_dq,
   output logic            o_cs_n,
   output logic            o_sclk,
   output logic [3:0]      o_dq
);
   localparam int HALF = 6; // Keeps serial clock under the sampling limit
   // Idle lines at time zero
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_dq   = 4'hA;
   end
   // Half bit: hold, then move the serial clock
   task automatic tick(input logic lvl);
      repeat (HALF) @(posedge i_clk);
      o_sclk <= lvl;
   endtask
   // Bytes MSB first, then dummy and one reply byte on wire 1
   task automatic frame(input logic [31:0] tx, input int nb,
                        input bit rd, output logic [7:0] rx);
      int bpc;
      int k;
      rx  = 8'h00;
      @(posedge i_clk);
      // Width read after the edge, so a mode just set is seen
      bpc = (i_width == 2'h2) ? 4 : (i_width == 2'h1) ? 2 : 1;
      o_cs_n <= 1'b0;
      for (k = 0; k < nb * 8; k = k + bpc) begin
         o_dq <= 4'((tx << k) >> (32 - bpc));
         tick(1'b1);
         tick(1'b0);
      end
      for (k = 0; k < (rd ? 16 : 0); k++) begin
         o_dq <= ~o_dq; // Released lines never hold a stale bit
         repeat (HALF - 1) @(posedge i_clk);
         if (k > 7) rx = {rx[6:0], i_dq[1]};
         tick(1'b1);
         tick(1'b0);
      end
      tick(1'b0);
      o_cs_n <= 1'b1;
      o_dq   <= ~o_dq;
      repeat (4 * HALF) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ### bench/fsr_core_tb.sv
// Self-checking bench for the status, soft reset and parameter core
`timescale 1ns/1ps
`default_nettype none
module fsr_core_tb;
   logic       i_clk;
   logic       i_rst;
   logic [1:0] i_width;
   logic [7:0] i_nv_status;
   logic       cs_n;
   logic       sclk;
   logic [3:0] h_dq;
   logic [3:0] d_dq;
   logic [3:0] d_oe;
   logic [3:0] dq_w;
   logic [7:0] status;
   logic [7:0] nv_wdata;
   logic [7:0] rx;
   logic [7:0] v;
   logic       nv_we;
   logic       soft_rst;
   int         n_errors;
   int         check_count;
   int         n_rst;
   int         n_we;
   // Shared wire: design wins where it enables
   assign dq_w = (d_oe & d_dq) | (~d_oe & h_dq);
   fsr_core uut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_dq(dq_w), .i_width(i_width),
      .i_nv_status(i_nv_status), .o_dq(d_dq), .o_dq_oe(d_oe),
      .o_status(status), .o_nv_wdata(nv_wdata), .o_nv_we(nv_we),
      .o_soft_rst(soft_rst));
   fsr_host_model host (.i_clk(i_clk), .i_width(i_width),
      .i_dq(dq_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(h_dq));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Pulse counters, so late pulses are still seen
   always @(posedge i_clk) begin
      if (soft_rst === 1'b1) n_rst++;
      if (nv_we === 1'b1) n_we++;
   end
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic op(logic [7:0] c, logic [7:0] d, int nb);
      host.frame({c, d, 16'h0000}, nb, 1'b0, rx);
   endtask
   function automatic logic [7:0] par_exp(logic [7:0] a);
      case (a)
         8'h6C: return 8'hE8;
         8'h6D: return 8'h10;
         8'h6E: return 8'hC0;
         8'h6F: return 8'h80;
         default: return 8'hFF; // Unmapped bytes read as reserved
      endcase
   endfunction
   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(88889));
      i_rst = 1'b1;
      i_width = 2'h0;
      i_nv_status = 8'($urandom);
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      check("power-up", status, i_nv_status);
      for (int w = 0; w < 3; w++) begin
         i_width <= w[1:0];
         i_nv_status <= 8'($urandom);
         op(8'h66, 8'h00, 1);
         op(8'h99, 8'h00, 1);
         check("reset count", 8'(n_rst), 8'(w + 1));
         check("reload", status, i_nv_status);
      end
      i_width <= 2'h0;
      op(8'h66, 8'h00, 1);
      op(8'h05, 8'h00, 1);
      op(8'h99, 8'h00, 1);
      op(8'h99, 8'h00, 1);
      check("broken pair", 8'(n_rst), 8'h03);
      v = 8'($urandom);
      op(8'h01, v, 2);
      check("locked we", 8'(n_we), 8'h00);
      check("locked st", status, i_nv_status);
      op(8'h06, 8'h00, 1);
      op(8'h01, v, 2);
      check("stored we", 8'(n_we), 8'h01);
      check("stored data", nv_wdata, v);
      check("stored st", status, v);
      // Stored copy now holds v, as the outside store would
      i_nv_status <= v;
      op(8'h50, 8'h00, 1);
      op(8'h01, ~v, 2);
      check("volatile", status, ~v);
      check("volatile we", 8'(n_we), 8'h01);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      check("rerun load", status, v);
      for (int k = 0; k < 7; k++) begin
         v = (k < 5) ? 8'(8'h6C + k) : 8'($urandom);
         host.frame({8'h5A, 16'h0000, v}, 4, 1'b1, rx);
         check("param byte", rx, par_exp(v));
      end
      final_report();
   end
   initial begin
      #500000;
      n_errors++;
      final_report();
   end
endmodule
bind fsr_core fsr_properties u_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_cs_n(i_cs_n), .i_nv_status(i_nv_status), .o_dq_oe(o_dq_oe),
   .o_status(o_status), .o_nv_we(o_nv_we), .o_soft_rst(o_soft_rst));
`default_nettype wire
